// File: pkd_map.vh
/*
 * Register offsets, field positions, reset values and timing figures
 * for the power-key press detector.
 * Assumes a 200 MHz system clock and a 32-bit AXI4-Lite register bus.
 */
`ifndef PKD_MAP_VH
`define PKD_MAP_VH

// Register byte offsets
`define PKD_CTRL_OFS 8'h00
`define PKD_DEB_OFS 8'h04
`define PKD_DELAY_OFS 8'h08
`define PKD_STAT_OFS 8'h0c
`define PKD_EVT_OFS 8'h10
`define PKD_MASK_OFS 8'h14

// Control register fields
`define PKD_CTRL_SEL_LO 0
`define PKD_CTRL_SEL_HI 1
`define PKD_CTRL_LOCK 2
`define PKD_CTRL_SYSEN 3
`define PKD_CTRL_STBY 4

// Status, event and mask fields
`define PKD_STAT_LEVEL 0
`define PKD_STAT_TIMING 1
`define PKD_EVT_KEY 0

// Reset values
`define PKD_SEL_RST 2'h0
`define PKD_SYSEN_RST 1'h1
`define PKD_DEB_RST 8'h0a
`define PKD_DELAY_RST 16'h07d0

// Timing: one filter and timer tick is 1000 us
`define PKD_TICK_US 1000
`define PKD_CLK_MHZ 200

// Bus responses
`define PKD_RESP_OKAY 2'h0
`define PKD_RESP_SLVERR 2'h2

`endif

// File: pkd_top.v
/*
 * Power-key press detector: debounce filter, press timer, key event,
 * long-press lock, wakeup request and system-enable/standby controls,
 * with an AXI4-Lite register slave and one level interrupt.
 * Assumes one 200 MHz clock that runs in every power mode, an
 * asynchronous key pin, and a sequencer that reports power-down mode.
 */
// The implementer's own choices: the register addresses and register access over AXI4-Lite.

// Operation
// - Key pin is debounced by a filter time shared with other control inputs.
// - Press and release edges are detected and the time between them measured.
// - Edge detection and press timing keep running in every power mode.
// - Debounced key level is readable as a status bit.
// - Event mask suppresses both the interrupt and the wakeup of a key event.
// - Select 00: event on press, interrupt if unmasked, wakeup in power-down.
// - Select 01: short press event at release; long press event and lock.
// - Select 10: as 01, but long press also clears system enable.
// - Select 11: short clears enable, sets standby; long clears both, sets lock.
// - With lock set, only a press reaching the long time wakes from power-down.
`timescale 1ns/10ps
`include "pkd_map.vh"

module pkd_top #(
    parameter TICK_CYC = `PKD_TICK_US * `PKD_CLK_MHZ
) (
    input wire sys_clk,
    input wire rst,
    input wire power_key_input,
    input wire power_down_mode,
    output wire [63:0] debounce_time_out,
    input wire [31:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [31:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    output reg irq,
    output reg wakeup_req,
    output reg system_en,
    output reg standby,
    output reg long_press_lock
);

    localparam [31:0] TICK_LAST = TICK_CYC - 1;

    reg [31:0] tick_cnt_r;
    reg tick_r;
    reg [2:0] key_sync_r;
    reg key_level_r;
    reg [7:0] deb_cnt_r;
    reg key_prev_r;
    reg [15:0] press_cnt_r;
    reg timing_r;
    reg long_done_r;
    reg [1:0] key_function_sel_r;
    reg [7:0] deb_time_r;
    reg [15:0] key_delay_r;
    reg key_event_flag_r;
    reg key_event_mask_r;
    reg [7:0] aw_addr_r;
    reg aw_have_r;
    reg [31:0] w_data_r;
    reg [3:0] w_strb_r;
    reg w_have_r;

    wire press_edge;
    wire release_edge;
    wire long_reach;
    wire short_release;
    wire key_event;
    wire wr_go;
    wire wr_ctrl;
    wire wr_hit;
    wire [7:0] ar_ofs;

    // Shared filter time is offered to the other control inputs
    assign debounce_time_out = {56'h0, deb_time_r};

    // Free-running tick divider, never gated by power mode
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            tick_cnt_r <= 32'h0;
            tick_r <= 1'b0;
        end else if (tick_cnt_r == TICK_LAST) begin
            tick_cnt_r <= 32'h0;
            tick_r <= 1'b1;
        end else begin
            tick_cnt_r <= tick_cnt_r + 32'h1;
            tick_r <= 1'b0;
        end
    end

    // Pin synchroniser; idle level of the active-low key is high
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            key_sync_r <= 3'h7;
        end else begin
            key_sync_r <= {key_sync_r[1:0], power_key_input};
        end
    end

    // Debounce: a new level must hold for the shared filter time
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            key_level_r <= 1'b1;
            deb_cnt_r <= 8'h0;
        end else if (key_sync_r[1] != key_sync_r[2] || key_sync_r[2] == key_level_r) begin
            deb_cnt_r <= 8'h0;
        end else if (deb_cnt_r >= deb_time_r) begin
            key_level_r <= key_sync_r[2];
            deb_cnt_r <= 8'h0;
        end else if (tick_r) begin
            deb_cnt_r <= deb_cnt_r + 8'h1;
        end
    end

    // Edge detection on the debounced level
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            key_prev_r <= 1'b1;
        end else begin
            key_prev_r <= key_level_r;
        end
    end

    assign press_edge = key_prev_r & ~key_level_r;
    assign release_edge = ~key_prev_r & key_level_r;

    // Press timer: counts ticks from press until the long-press time
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            press_cnt_r <= 16'h0;
            timing_r <= 1'b0;
            long_done_r <= 1'b0;
        end else if (press_edge) begin
            press_cnt_r <= 16'h0;
            timing_r <= 1'b1;
            long_done_r <= 1'b0;
        end else if (release_edge) begin
            timing_r <= 1'b0;
        end else if (long_reach) begin
            timing_r <= 1'b0;
            long_done_r <= 1'b1;
        end else if (timing_r && tick_r) begin
            press_cnt_r <= press_cnt_r + 16'h1;
        end
    end

    // Long press reached while still held; programmable time
    assign long_reach = timing_r & ~key_level_r & (press_cnt_r >= key_delay_r);
    assign short_release = release_edge & timing_r & ~long_done_r;

    // Event source per function select
    assign key_event = (key_function_sel_r == 2'h0) ? press_edge :
        (short_release | long_reach);

    // Write channel capture, address and data in either order
    assign wr_go = aw_have_r & w_have_r & ~s_axi_bvalid;
    assign wr_ctrl = wr_go & (aw_addr_r == `PKD_CTRL_OFS) & w_strb_r[0];
    assign wr_hit = (aw_addr_r == `PKD_CTRL_OFS) | (aw_addr_r == `PKD_DEB_OFS) |
        (aw_addr_r == `PKD_DELAY_OFS) | (aw_addr_r == `PKD_STAT_OFS) |
        (aw_addr_r == `PKD_EVT_OFS) | (aw_addr_r == `PKD_MASK_OFS);

    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            aw_have_r <= 1'b0;
            aw_addr_r <= 8'h0;
            s_axi_awready <= 1'b1;
            w_have_r <= 1'b0;
            w_data_r <= 32'h0;
            w_strb_r <= 4'h0;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `PKD_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr_r <= {s_axi_awaddr[7:2], 2'h0};
                aw_have_r <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
                w_have_r <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? `PKD_RESP_OKAY : `PKD_RESP_SLVERR;
                aw_have_r <= 1'b0;
                w_have_r <= 1'b0;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // Software configuration registers
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            key_function_sel_r <= `PKD_SEL_RST;
            deb_time_r <= `PKD_DEB_RST;
            key_delay_r <= `PKD_DELAY_RST;
            key_event_mask_r <= 1'b0;
        end else if (wr_go) begin
            if (wr_ctrl) begin
                key_function_sel_r <= w_data_r[`PKD_CTRL_SEL_HI:`PKD_CTRL_SEL_LO];
            end
            if (aw_addr_r == `PKD_DEB_OFS && w_strb_r[0]) begin
                deb_time_r <= w_data_r[7:0];
            end
            if (aw_addr_r == `PKD_DELAY_OFS) begin
                if (w_strb_r[0]) begin
                    key_delay_r[7:0] <= w_data_r[7:0];
                end
                if (w_strb_r[1]) begin
                    key_delay_r[15:8] <= w_data_r[15:8];
                end
            end
            if (aw_addr_r == `PKD_MASK_OFS && w_strb_r[0]) begin
                key_event_mask_r <= w_data_r[`PKD_EVT_KEY];
            end
        end
    end

    // Lock: hardware set wins, cleared only by a software write of zero
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            long_press_lock <= 1'b0;
        end else if (long_reach && key_function_sel_r != 2'h0) begin
            long_press_lock <= 1'b1;
        end else if (wr_ctrl) begin
            long_press_lock <= w_data_r[`PKD_CTRL_LOCK];
        end
    end

    // System enable and standby: key actions take priority over software
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            system_en <= `PKD_SYSEN_RST;
            standby <= 1'b0;
        end else if (long_reach && key_function_sel_r == 2'h2) begin
            system_en <= 1'b0;
        end else if (long_reach && key_function_sel_r == 2'h3) begin
            system_en <= 1'b0;
            standby <= 1'b0;
        end else if (short_release && key_function_sel_r == 2'h3) begin
            system_en <= 1'b0;
            standby <= 1'b1;
        end else if (wr_ctrl) begin
            system_en <= w_data_r[`PKD_CTRL_SYSEN];
            standby <= w_data_r[`PKD_CTRL_STBY];
        end
    end

    // Sticky event flag, write one to clear; a new event wins
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            key_event_flag_r <= 1'b0;
        end else if (key_event) begin
            key_event_flag_r <= 1'b1;
        end else if (wr_go && aw_addr_r == `PKD_EVT_OFS && w_strb_r[0] &&
                     w_data_r[`PKD_EVT_KEY]) begin
            key_event_flag_r <= 1'b0;
        end
    end

    // Interrupt and wakeup, both gated by the event mask
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            irq <= 1'b0;
            wakeup_req <= 1'b0;
        end else begin
            irq <= key_event_flag_r & ~key_event_mask_r;
            wakeup_req <= key_event & power_down_mode & ~key_event_mask_r &
                (~long_press_lock | long_reach);
        end
    end

    // Read channel: one cycle from address to data
    assign ar_ofs = {s_axi_araddr[7:2], 2'h0};

    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `PKD_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `PKD_RESP_OKAY;
            case (ar_ofs)
                `PKD_CTRL_OFS: begin
                    s_axi_rdata <= {27'h0, standby, system_en, long_press_lock,
                        key_function_sel_r};
                end
                `PKD_DEB_OFS: begin
                    s_axi_rdata <= {24'h0, deb_time_r};
                end
                `PKD_DELAY_OFS: begin
                    s_axi_rdata <= {16'h0, key_delay_r};
                end
                `PKD_STAT_OFS: begin
                    s_axi_rdata <= {30'h0, timing_r, key_level_r};
                end
                `PKD_EVT_OFS: begin
                    s_axi_rdata <= {31'h0, key_event_flag_r};
                end
                `PKD_MASK_OFS: begin
                    s_axi_rdata <= {31'h0, key_event_mask_r};
                end
                default: begin
                    s_axi_rdata <= 32'h0;
                    s_axi_rresp <= `PKD_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

endmodule // pkd_top

// File: pkd_key_model.sv
/* Push-button model that drives the key pin.
   Assumes the bench drives press; the pin has a pull-up. */
`timescale 1ns/10ps
module pkd_key_model (
    input wire logic press,
    output wire logic key_n
);
    // Closed button pulls low; open button leaves the pull-up level
    assign key_n = press ? 1'b0 : 1'b1;
endmodule // pkd_key_model

// File: pkd_top_sva.sv
/* Checker on the key detector's ports.
   Assumes one clock domain and an active-high reset. */
`timescale 1ns/10ps
module pkd_top_sva (
    input wire sys_clk,
    input wire rst,
    input wire power_down_mode,
    input wire s_axi_awready,
    input wire s_axi_wready,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arready,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire [31:0] s_axi_rdata,
    input wire irq,
    input wire wakeup_req,
    input wire long_press_lock
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    // Wakeup is a single pulse, only in power-down, always with an interrupt
    chk_wake_pulse: assert property (wakeup_req |=> !wakeup_req)
        else $error("wakeup pulse too long");
    chk_wake_in_pd: assert property (wakeup_req |-> $past(power_down_mode))
        else $error("wakeup outside power-down");
    chk_wake_irq: assert property (wakeup_req |-> ##[0:2] irq)
        else $error("wakeup without interrupt");
    // Lock only drops while a register write is in progress
    chk_lock_hold: assert property ($fell(long_press_lock) |-> !s_axi_wready)
        else $error("lock cleared without a write");
    // Bus answers hold until taken and block new requests
    chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");
    chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    chk_w_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while answering");
    chk_r_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answering");
endmodule // pkd_top_sva

bind pkd_top pkd_top_sva u_sva (.sys_clk(sys_clk), .rst(rst), .power_down_mode(power_down_mode),
    .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .irq(irq),
    .wakeup_req(wakeup_req), .long_press_lock(long_press_lock));

// File: pkd_top_tb.sv
/* Self-checking bench for the key detector.
   Assumes a fast tick parameter so presses last under two hundred cycles. */
`timescale 1ns/10ps
`include "pkd_map.vh"
module pkd_top_tb;
    logic sys_clk = 0, rst = 1, press = 0, pd = 0, key_n;
    logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata, d;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid, irq, wakeup_req, system_en, standby;
    logic long_press_lock;
    logic [1:0] bresp, rresp, r, b;
    logic [63:0] deb_out;
    // Rows: select, long, expected lock, system enable, standby
    logic [5:0] rows [7] = '{6'h02, 6'h12, 6'h1e, 6'h22, 6'h2c, 6'h31, 6'h3c};
    logic [5:0] row;
    int num_errors = 0, n_checks = 0, wake_n = 0, i;

    pkd_key_model KEY (.press(press), .key_n(key_n));
    pkd_top #(.TICK_CYC(10)) DUT (.sys_clk(sys_clk), .rst(rst), .power_key_input(key_n),
        .power_down_mode(pd), .debounce_time_out(deb_out), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .irq(irq), .wakeup_req(wakeup_req), .system_en(system_en),
        .standby(standby), .long_press_lock(long_press_lock));

    // 200 MHz clock
    always #2.5 sys_clk = ~sys_clk;
    // Counts wakeup pulses
    always @(posedge sys_clk) if (wakeup_req === 1'b1) wake_n <= wake_n + 1;

    task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge sys_clk);
        awaddr <= {24'h0, a};
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!(bvalid && bready));
        b = bresp;
        bready <= 1'b0;
    endtask

    task rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] e);
        @(posedge sys_clk);
        araddr <= {24'h0, a};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!(rvalid && rready));
        v = rdata;
        e = rresp;
        rready <= 1'b0;
    endtask

    // Holds the key, checks the level mid-press, then releases and settles
    task press_key(input int hold);
        @(posedge sys_clk);
        press <= 1'b1;
        repeat (40) @(posedge sys_clk);
        rd(`PKD_STAT_OFS, d, r);
        chk("key level", 32'h0, {31'h0, d[0]});
        chk("timer running", 32'h1, {31'h0, d[1]});
        repeat (hold) @(posedge sys_clk);
        press <= 1'b0;
        repeat (60) @(posedge sys_clk);
    endtask

    task wrap_up;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
        rd(`PKD_CTRL_OFS, d, r);
        chk("ctrl reset", 32'h08, d);
        rd(`PKD_DEB_OFS, d, r);
        chk("deb reset", {24'h0, `PKD_DEB_RST}, d);
        rd(`PKD_DELAY_OFS, d, r);
        chk("delay reset", {16'h0, `PKD_DELAY_RST}, d);
        rd(8'h18, d, r);
        chk("unmapped resp", {30'h0, `PKD_RESP_SLVERR}, {30'h0, r});
        chk("unmapped data", 32'h0, d);
        wr(8'h18, 32'hff);
        chk("unmapped wr", {30'h0, `PKD_RESP_SLVERR}, {30'h0, b});
        wr(`PKD_DEB_OFS, 32'h2);
        wr(`PKD_DELAY_OFS, 32'h8);
        chk("wr resp", {30'h0, `PKD_RESP_OKAY}, {30'h0, b});
        chk("filter out", 32'h2, deb_out[31:0]);
        // A glitch shorter than the filter gives no event
        press <= 1'b1;
        repeat (5) @(posedge sys_clk);
        press <= 1'b0;
        repeat (40) @(posedge sys_clk);
        rd(`PKD_EVT_OFS, d, r);
        chk("glitch event", 32'h0, d);
        // Every select with a short press, and long presses for selects 01 to 11
        for (i = 0; i < 7; i++) begin
            row = rows[i];
            wr(`PKD_CTRL_OFS, {27'h0, 3'h2, row[5:4]});
            wr(`PKD_EVT_OFS, 32'h1);
            press_key(row[3] ? 120 : 10);
            rd(`PKD_EVT_OFS, d, r);
            chk("event flag", 32'h1, d);
            rd(`PKD_CTRL_OFS, d, r);
            chk("ctrl", {27'h0, row[0], row[1], row[2], row[5:4]}, d);
            chk("lock pin", {31'h0, row[2]}, {31'h0, long_press_lock});
            chk("en pins", {30'h0, row[1], row[0]}, {30'h0, system_en, standby});
        end
        // Masked and unmasked wakeup in power-down
        pd <= 1'b1;
        wr(`PKD_CTRL_OFS, 32'h08);
        wr(`PKD_EVT_OFS, 32'h1);
        wr(`PKD_MASK_OFS, 32'h1);
        press_key(10);
        chk("masked wake", 32'h0, wake_n);
        chk("masked irq", 32'h0, {31'h0, irq});
        rd(`PKD_EVT_OFS, d, r);
        chk("pd event", 32'h1, d);
        wr(`PKD_MASK_OFS, 32'h0);
        press_key(10);
        chk("wake", 32'h1, wake_n);
        chk("irq", 32'h1, {31'h0, irq});
        wr(`PKD_EVT_OFS, 32'h1);
        repeat (2) @(posedge sys_clk);
        chk("irq cleared", 32'h0, {31'h0, irq});
        // Lock: only a long press wakes until software clears it
        wr(`PKD_CTRL_OFS, 32'h09);
        press_key(120);
        chk("long wake", 32'h2, wake_n);
        chk("lock set", 32'h1, {31'h0, long_press_lock});
        press_key(10);
        chk("locked short", 32'h2, wake_n);
        chk("lock held", 32'h1, {31'h0, long_press_lock});
        wr(`PKD_CTRL_OFS, 32'h09);
        chk("lock cleared", 32'h0, {31'h0, long_press_lock});
        press_key(10);
        chk("unlocked short", 32'h3, wake_n);
        // Reset in mid-run returns pins and registers to their reset values
        wr(`PKD_CTRL_OFS, 32'h14);
        chk("ctrl pins", 32'h3, {29'h0, system_en, standby, long_press_lock});
        @(posedge sys_clk);
        rst <= 1'b1;
        repeat (3) @(posedge sys_clk);
        chk("reset pins", 32'h4, {29'h0, system_en, standby, long_press_lock});
        chk("reset irq", 32'h0, {31'h0, irq});
        rst <= 1'b0;
        rd(`PKD_CTRL_OFS, d, r);
        chk("ctrl re-reset", 32'h08, d);
        rd(`PKD_EVT_OFS, d, r);
        chk("event re-reset", 32'h0, d);
        wrap_up;
    end

    // Watchdog
    initial begin
        #100000;
        num_errors++;
        wrap_up;
    end
endmodule // pkd_top_tb
